// >>> src/acb_pkg.sv
// constants, masks and types for the analog clock and buffer configuration bank
package acb_pkg;

    // ******************************************************************
    // bus widths, offsets and reset values
    // ******************************************************************
    localparam int unsigned ACB_AW = 8;
    localparam int unsigned ACB_DW = 8;
    localparam logic [7:0] ACB_OFS_CLK_SRC  = 8'h61;
    localparam logic [7:0] ACB_OFS_BUF_CTRL = 8'h62;
    localparam logic [7:0] ACB_OFS_STATUS   = 8'h68;
    localparam logic [7:0] ACB_RST_CLK_SRC  = 8'h00;
    localparam logic [7:0] ACB_RST_BUF_CTRL = 8'h00;
    localparam logic [7:0] ACB_RST_STATUS   = 8'h00;
    localparam logic [7:0] ACB_ZERO_BYTE    = 8'h00;

    // ******************************************************************
    // clock source and buffer control fields
    // ******************************************************************
    localparam int unsigned ACB_SEL_W      = 3;
    localparam int unsigned ACB_NUM_BLOCKS = 8;
    localparam int unsigned ACB_SAMPLE_HOLD_DISABLE_BIT  = 6;
    localparam int unsigned ACB_CLK1_LSB   = 3;
    localparam int unsigned ACB_CLK0_LSB   = 0;
    localparam int unsigned ACB_COL1_SEL_BIT = 7;
    localparam int unsigned ACB_COL2_SEL_BIT = 6;
    localparam int unsigned ACB_BUF1_EN_BIT  = 5;
    localparam int unsigned ACB_BUF2_EN_BIT  = 4;
    localparam int unsigned ACB_BUF0_EN_BIT  = 3;
    localparam int unsigned ACB_BUF3_EN_BIT  = 2;
    localparam int unsigned ACB_BYPASS_BIT   = 1;
    localparam int unsigned ACB_POWER_BIT    = 0;

    // ******************************************************************
    // status register fields
    // ******************************************************************
    localparam int unsigned ACB_ST_CLK0_BIT    = 0;
    localparam int unsigned ACB_ST_CLK1_BIT    = 1;
    localparam int unsigned ACB_ST_RSV0_BIT    = 2;
    localparam int unsigned ACB_ST_RSV1_BIT    = 3;
    localparam int unsigned ACB_ST_BADWR_BIT   = 4;
    localparam int unsigned ACB_ST_BADCODE_BIT = 5;
    localparam logic [7:0]  ACB_ST_W1C_MASK    = 8'h30;

    // ******************************************************************
    // implemented bits per variant
    // ******************************************************************
    localparam logic [7:0] ACB_CLK_MASK_FULL = 8'h7f;
    localparam logic [7:0] ACB_CLK_MASK_NONE = 8'h00;
    localparam logic [7:0] ACB_BUF_MASK_FOUR = 8'hff;
    localparam logic [7:0] ACB_BUF_MASK_TWO  = 8'hab;
    localparam logic [7:0] ACB_BUF_MASK_LIM  = 8'h80;
    localparam logic [7:0] ACB_BUF_MASK_ONE  = 8'ha3;

    // ******************************************************************
    // device variants
    // ******************************************************************
    typedef enum logic [1:0] {
        ACB_VAR_FOUR    = 2'b00,
        ACB_VAR_TWO     = 2'b01,
        ACB_VAR_TWO_LIM = 2'b10,
        ACB_VAR_ONE     = 2'b11
    } acb_variant_t;

endpackage

// >>> src/acb_clk_src_sel.sv
// one analog clock source selector with registered output
`timescale 1ns/10ps
module acb_clk_src_sel #(
    parameter bit          SMALL_DEVICE = 1'b0,
    parameter int unsigned NUM_BLOCKS   = acb_pkg::ACB_NUM_BLOCKS,
    parameter int unsigned SEL_W        = acb_pkg::ACB_SEL_W
) (
    // clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  reset_n_i,
    // selection
    input  wire logic                  enable_i,
    input  wire logic                  range_i,
    input  wire logic [SEL_W-1:0]      code_i,
    // digital block primary outputs, one vector per range
    input  wire logic [NUM_BLOCKS-1:0] block_out_r0_i,
    input  wire logic [NUM_BLOCKS-1:0] block_out_r1_i,
    // result
    output logic                       clk_o,
    output logic                       reserved_o
);

    // ******************************************************************
    // selection
    // ******************************************************************
    wire logic code_reserved;
    wire logic picked;
    logic      clk_q;
    logic      reserved_q;

    // upper codes name the second block row, absent on the small device
    assign code_reserved = SMALL_DEVICE & code_i[SEL_W-1];
    assign picked        = range_i ? block_out_r1_i[code_i] : block_out_r0_i[code_i];

    // ******************************************************************
    // output register
    // ******************************************************************
    // reserved codes park the clock low rather than pick an absent block
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            clk_q      <= 1'b0;
            reserved_q <= 1'b0;
        end else begin
            clk_q      <= enable_i & ~code_reserved & picked;
            reserved_q <= enable_i & code_reserved;
        end
    end

    assign clk_o      = clk_q;
    assign reserved_o = reserved_q;

endmodule

// >>> src/acb_config_bank.sv
// analog clock source and analog output buffer configuration bank
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps

module acb_config_bank #(
    parameter acb_pkg::acb_variant_t VARIANT      = acb_pkg::ACB_VAR_FOUR,
    parameter bit                    SMALL_DEVICE = 1'b0,
    parameter int unsigned           NUM_BLOCKS   = acb_pkg::ACB_NUM_BLOCKS
) (
    // clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       reset_n_i,
    // register port
    input  wire logic [acb_pkg::ACB_AW-1:0] reg_addr_i,
    input  wire logic [acb_pkg::ACB_DW-1:0] reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [acb_pkg::ACB_DW-1:0] reg_rdata_o,
    // range bits from the clock range register
    input  wire logic                       clock_zero_range_bit_i,
    input  wire logic                       clock_one_range_bit_i,
    // digital block primary outputs
    input  wire logic [NUM_BLOCKS-1:0]      block_out_r0_i,
    input  wire logic [NUM_BLOCKS-1:0]      block_out_r1_i,
    // analog clocks
    output logic                            analog_clock_zero_o,
    output logic                            analog_clock_one_o,
    output logic                            sample_hold_disable_o,
    // column input routing
    output logic                            column_one_input_select_o,
    output logic                            column_two_input_select_o,
    output logic                            column_one_odd_group_o,
    // analog output buffers
    output logic                            column_zero_buffer_enable_o,
    output logic                            column_one_buffer_enable_o,
    output logic                            column_two_buffer_enable_o,
    output logic                            column_three_buffer_enable_o,
    output logic                            buffer_bypass_o,
    output logic                            buffer_power_level_o
);

    // ******************************************************************
    // variant decoding
    // ******************************************************************
    localparam bit IS_ONE_COLUMN = (VARIANT == acb_pkg::ACB_VAR_ONE);

    // implemented bits of a register for this variant; unmapped gives none
    function automatic logic [7:0] acb_impl_mask(input acb_pkg::acb_variant_t var_i,
                                                 input logic [7:0]            addr_i);
        logic [7:0] mask;
        mask = acb_pkg::ACB_ZERO_BYTE;
        if (addr_i == acb_pkg::ACB_OFS_CLK_SRC) begin
            mask = (var_i == acb_pkg::ACB_VAR_ONE) ? acb_pkg::ACB_CLK_MASK_NONE :
                                                     acb_pkg::ACB_CLK_MASK_FULL;
        end else if (addr_i == acb_pkg::ACB_OFS_BUF_CTRL) begin
            unique case (var_i)
                acb_pkg::ACB_VAR_FOUR:    mask = acb_pkg::ACB_BUF_MASK_FOUR;
                acb_pkg::ACB_VAR_TWO:     mask = acb_pkg::ACB_BUF_MASK_TWO;
                acb_pkg::ACB_VAR_TWO_LIM: mask = acb_pkg::ACB_BUF_MASK_LIM;
                acb_pkg::ACB_VAR_ONE:     mask = acb_pkg::ACB_BUF_MASK_ONE;
            endcase
        end
        return mask;
    endfunction

    // ******************************************************************
    // registers
    // ******************************************************************
    logic [7:0] clk_src_q;
    logic [7:0] clk_src_d;
    logic [7:0] buf_ctrl_q;
    logic [7:0] buf_ctrl_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       odd_group_q;
    logic       odd_group_d;
    logic       col1_sel_q;
    logic       col1_sel_d;

    // ******************************************************************
    // address decode
    // ******************************************************************
    wire logic       hit_clk_src;
    wire logic       hit_buf_ctrl;
    wire logic       hit_status;
    wire logic       wr_clk_src;
    wire logic       wr_buf_ctrl;
    wire logic       wr_status;
    wire logic [7:0] clk_src_mask;
    wire logic [7:0] buf_ctrl_mask;
    wire logic [7:0] wr_addr_mask;
    wire logic       bad_write;

    assign clk_src_mask  = acb_impl_mask(VARIANT, acb_pkg::ACB_OFS_CLK_SRC);
    assign buf_ctrl_mask = acb_impl_mask(VARIANT, acb_pkg::ACB_OFS_BUF_CTRL);
    assign wr_addr_mask  = acb_impl_mask(VARIANT, reg_addr_i);

    // single column parts have no clock source register at all
    assign hit_clk_src  = (reg_addr_i == acb_pkg::ACB_OFS_CLK_SRC) & ~IS_ONE_COLUMN;
    assign hit_buf_ctrl = (reg_addr_i == acb_pkg::ACB_OFS_BUF_CTRL);
    assign hit_status   = (reg_addr_i == acb_pkg::ACB_OFS_STATUS);
    assign wr_clk_src   = reg_wr_i & hit_clk_src;
    assign wr_buf_ctrl  = reg_wr_i & hit_buf_ctrl;
    assign wr_status    = reg_wr_i & hit_status;

    // a one into a reserved bit is dropped and reported, never stored
    assign bad_write = (wr_clk_src | wr_buf_ctrl) & (|(reg_wdata_i & ~wr_addr_mask));

    // ******************************************************************
    // next values of the control registers
    // ******************************************************************
    // write takes effect at the edge that ends the write cycle
    assign clk_src_d  = wr_clk_src  ? (reg_wdata_i & clk_src_mask)  : clk_src_q;
    assign buf_ctrl_d = wr_buf_ctrl ? (reg_wdata_i & buf_ctrl_mask) : buf_ctrl_q;

    // on one column parts bit 7 steers the port group, not a column mux
    assign odd_group_d = IS_ONE_COLUMN & buf_ctrl_d[acb_pkg::ACB_COL1_SEL_BIT];
    assign col1_sel_d  = ~IS_ONE_COLUMN & buf_ctrl_d[acb_pkg::ACB_COL1_SEL_BIT];

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            clk_src_q   <= acb_pkg::ACB_RST_CLK_SRC;
            buf_ctrl_q  <= acb_pkg::ACB_RST_BUF_CTRL;
            odd_group_q <= 1'b0;
            col1_sel_q  <= 1'b0;
        end else begin
            clk_src_q   <= clk_src_d;
            buf_ctrl_q  <= buf_ctrl_d;
            odd_group_q <= odd_group_d;
            col1_sel_q  <= col1_sel_d;
        end
    end

    // ******************************************************************
    // analog clock selectors
    // ******************************************************************
    wire logic [acb_pkg::ACB_SEL_W-1:0] sel_code  [2];
    wire logic                          sel_range [2];
    wire logic [1:0]                    sel_clk;
    wire logic [1:0]                    sel_rsv;
    wire logic                          sel_enable;

    assign sel_code[0]  = clk_src_q[acb_pkg::ACB_CLK0_LSB +: acb_pkg::ACB_SEL_W];
    assign sel_code[1]  = clk_src_q[acb_pkg::ACB_CLK1_LSB +: acb_pkg::ACB_SEL_W];
    assign sel_range[0] = clock_zero_range_bit_i;
    assign sel_range[1] = clock_one_range_bit_i;
    assign sel_enable   = ~IS_ONE_COLUMN;

    generate
        for (genvar g = 0; g < 2; g++) begin : g_sel
            // reserved codes are still accepted but give a quiet clock
            acb_clk_src_sel #(
                .SMALL_DEVICE (SMALL_DEVICE),
                .NUM_BLOCKS   (NUM_BLOCKS),
                .SEL_W        (acb_pkg::ACB_SEL_W)
            ) u_sel (
                .mclk_i         (mclk_i),
                .reset_n_i      (reset_n_i),
                .enable_i       (sel_enable),
                .range_i        (sel_range[g]),
                .code_i         (sel_code[g]),
                .block_out_r0_i (block_out_r0_i),
                .block_out_r1_i (block_out_r1_i),
                .clk_o          (sel_clk[g]),
                .reserved_o     (sel_rsv[g])
            );
        end
    endgenerate

    // ******************************************************************
    // status register
    // ******************************************************************
    wire logic [7:0] status_live;
    wire logic [7:0] status_set;
    wire logic [7:0] status_clr;

    assign status_live = {2'b00,
                          sel_rsv[1],
                          sel_rsv[0],
                          2'b00,
                          sel_clk[1],
                          sel_clk[0]};

    assign status_set = {2'b00,
                         |sel_rsv,
                         bad_write,
                         4'h0};

    assign status_clr = wr_status ? (reg_wdata_i & acb_pkg::ACB_ST_W1C_MASK) : acb_pkg::ACB_ZERO_BYTE;

    // sticky bits: a new event in the clearing cycle survives the clear
    assign status_d = (status_live & ~acb_pkg::ACB_ST_W1C_MASK) |
                      (((status_q & ~status_clr) | status_set) & acb_pkg::ACB_ST_W1C_MASK);

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            status_q <= acb_pkg::ACB_RST_STATUS;
        end else begin
            status_q <= status_d;
        end
    end

    // ******************************************************************
    // read path
    // ******************************************************************
    wire logic [7:0] rd_mux;

    // reserved bits and unmapped offsets read as zero
    assign rd_mux = hit_clk_src  ? (clk_src_q & clk_src_mask)   :
                    hit_buf_ctrl ? (buf_ctrl_q & buf_ctrl_mask) :
                    hit_status   ? status_q                     :
                                   acb_pkg::ACB_ZERO_BYTE;

    // data stand only in the cycle after the strobe
    assign rdata_d = reg_rd_i ? rd_mux : acb_pkg::ACB_ZERO_BYTE;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rdata_q <= acb_pkg::ACB_ZERO_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ******************************************************************
    // outputs
    // ******************************************************************
    assign reg_rdata_o                  = rdata_q;
    assign analog_clock_zero_o          = sel_clk[0];
    assign analog_clock_one_o           = sel_clk[1];
    assign sample_hold_disable_o        = clk_src_q[acb_pkg::ACB_SAMPLE_HOLD_DISABLE_BIT];
    assign column_one_input_select_o    = col1_sel_q;
    assign column_two_input_select_o    = buf_ctrl_q[acb_pkg::ACB_COL2_SEL_BIT];
    assign column_one_odd_group_o       = odd_group_q;
    assign column_one_buffer_enable_o   = buf_ctrl_q[acb_pkg::ACB_BUF1_EN_BIT];
    assign column_two_buffer_enable_o   = buf_ctrl_q[acb_pkg::ACB_BUF2_EN_BIT];
    assign column_zero_buffer_enable_o  = buf_ctrl_q[acb_pkg::ACB_BUF0_EN_BIT];
    assign column_three_buffer_enable_o = buf_ctrl_q[acb_pkg::ACB_BUF3_EN_BIT];
    // bypass does not gate the amplifiers; software turns them off first
    assign buffer_bypass_o              = buf_ctrl_q[acb_pkg::ACB_BYPASS_BIT];
    assign buffer_power_level_o         = buf_ctrl_q[acb_pkg::ACB_POWER_BIT];

endmodule

// >>> tb/acb_config_bank_chk.sv
// assertion checker for the analog clock and buffer configuration bank
`timescale 1ns/10ps
module acb_config_bank_chk #(
    parameter int unsigned NUM_BLOCKS = 8
) (
    // clock and reset
    input wire logic                       mclk_i,
    input wire logic                       reset_n_i,
    // register port
    input wire logic [acb_pkg::ACB_AW-1:0] reg_addr_i,
    input wire logic [acb_pkg::ACB_DW-1:0] reg_wdata_i,
    input wire logic                       reg_wr_i,
    input wire logic                       reg_rd_i,
    input wire logic [acb_pkg::ACB_DW-1:0] reg_rdata_o,
    // range bits and block outputs
    input wire logic                       clock_zero_range_bit_i,
    input wire logic                       clock_one_range_bit_i,
    input wire logic [NUM_BLOCKS-1:0]      block_out_r0_i,
    input wire logic [NUM_BLOCKS-1:0]      block_out_r1_i,
    // outputs
    input wire logic                       analog_clock_zero_o,
    input wire logic                       analog_clock_one_o,
    input wire logic                       sample_hold_disable_o,
    input wire logic                       column_one_input_select_o,
    input wire logic                       column_two_input_select_o,
    input wire logic                       column_one_odd_group_o,
    input wire logic                       column_zero_buffer_enable_o,
    input wire logic                       column_one_buffer_enable_o,
    input wire logic                       column_two_buffer_enable_o,
    input wire logic                       column_three_buffer_enable_o,
    input wire logic                       buffer_bypass_o,
    input wire logic                       buffer_power_level_o
);
    // ******************************************************************
    // shadow of the clock selectors
    // ******************************************************************
    logic [2:0] code0_q;
    logic [2:0] code1_q;
    wire        wr_clk = reg_wr_i && (reg_addr_i == acb_pkg::ACB_OFS_CLK_SRC);
    wire        wr_buf = reg_wr_i && (reg_addr_i == acb_pkg::ACB_OFS_BUF_CTRL);
    wire        rd_buf = reg_rd_i && (reg_addr_i == acb_pkg::ACB_OFS_BUF_CTRL);
    wire        sel0   = clock_zero_range_bit_i ? block_out_r1_i[code0_q] : block_out_r0_i[code0_q];
    wire        sel1   = clock_one_range_bit_i ? block_out_r1_i[code1_q] : block_out_r0_i[code1_q];
    wire [7:0]  pins   = {column_one_input_select_o, column_two_input_select_o, column_one_buffer_enable_o,
                          column_two_buffer_enable_o, column_zero_buffer_enable_o, column_three_buffer_enable_o,
                          buffer_bypass_o, buffer_power_level_o};

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            code0_q <= 3'h0;
            code1_q <= 3'h0;
        end else if (wr_clk) begin
            code0_q <= reg_wdata_i[2:0];
            code1_q <= reg_wdata_i[5:3];
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // ******************************************************************
    // properties
    // ******************************************************************
    property p_rdata_idle;
        !reg_rd_i |=> reg_rdata_o == 8'h00;
    endproperty
    property p_buf_write;
        wr_buf |=> pins == $past(reg_wdata_i);
    endproperty
    property p_buf_readback;
        rd_buf |=> reg_rdata_o == pins;
    endproperty
    property p_pins_hold;
        !wr_buf |=> $stable(pins);
    endproperty
    property p_sample_hold_disable_write;
        wr_clk |=> sample_hold_disable_o == $past(reg_wdata_i[6]);
    endproperty
    property p_sample_hold_disable_hold;
        !wr_clk |=> $stable(sample_hold_disable_o);
    endproperty
    // skip the edge that leaves reset
    property p_clk_zero;
        $past(reset_n_i) |=> analog_clock_zero_o == $past(sel0);
    endproperty
    property p_clk_one;
        $past(reset_n_i) |=> analog_clock_one_o == $past(sel1);
    endproperty
    property p_reset_clear;
        disable iff (1'b0) !reset_n_i |=> (pins == 8'h00) && (reg_rdata_o == 8'h00) && !sample_hold_disable_o;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
    a_buf_write: assert property (p_buf_write) else $error("buffer pins differ from write");
    a_buf_readback: assert property (p_buf_readback) else $error("buffer read differs from pins");
    a_pins_hold: assert property (p_pins_hold) else $error("buffer pins moved without write");
    a_sample_hold_disable_write: assert property (p_sample_hold_disable_write) else $error("hold disable differs from write");
    a_sample_hold_disable_hold: assert property (p_sample_hold_disable_hold) else $error("hold disable moved without write");
    a_clk_zero: assert property (p_clk_zero) else $error("clock zero source wrong");
    a_clk_one: assert property (p_clk_one) else $error("clock one source wrong");
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");

    c_clk_one: cover property (wr_clk ##1 analog_clock_one_o);
    c_read_buf: cover property (rd_buf ##1 reg_rdata_o != 8'h00);
    c_bypass: cover property (buffer_bypass_o && buffer_power_level_o);
endmodule

bind acb_config_bank acb_config_bank_chk #(.NUM_BLOCKS(NUM_BLOCKS)) u_chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .clock_zero_range_bit_i(clock_zero_range_bit_i), .clock_one_range_bit_i(clock_one_range_bit_i),
    .block_out_r0_i(block_out_r0_i), .block_out_r1_i(block_out_r1_i),
    .analog_clock_zero_o(analog_clock_zero_o), .analog_clock_one_o(analog_clock_one_o),
    .sample_hold_disable_o(sample_hold_disable_o), .column_one_input_select_o(column_one_input_select_o),
    .column_two_input_select_o(column_two_input_select_o), .column_one_odd_group_o(column_one_odd_group_o),
    .column_zero_buffer_enable_o(column_zero_buffer_enable_o),
    .column_one_buffer_enable_o(column_one_buffer_enable_o),
    .column_two_buffer_enable_o(column_two_buffer_enable_o),
    .column_three_buffer_enable_o(column_three_buffer_enable_o),
    .buffer_bypass_o(buffer_bypass_o), .buffer_power_level_o(buffer_power_level_o));

// >>> tb/acb_config_bank_test.sv
// self-checking bench for the analog clock and buffer configuration bank
`timescale 1ns/10ps
module acb_config_bank_test;
    // ******************************************************************
    // signals and bookkeeping
    // ******************************************************************
    logic       mclk_i                 = 1'b0;
    logic       reset_n_i              = 1'b0;
    logic [7:0] reg_addr_i             = 8'h00;
    logic [7:0] reg_wdata_i            = 8'h00;
    logic       reg_wr_i               = 1'b0;
    logic       reg_rd_i               = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       clock_zero_range_bit_i = 1'b0;
    logic       clock_one_range_bit_i  = 1'b0;
    logic [7:0] block_out_r0_i         = 8'h00;
    logic [7:0] block_out_r1_i         = 8'h00;
    logic       clk0, clk1, sample_hold_disable, col1_sel, col2_sel, odd_grp, en0, en1, en2, en3, bypass, power;
    wire  [7:0] pins = {col1_sel, col2_sel, en1, en2, en0, en3, bypass, power};
    int         seed       = 32'hab37;
    int         mismatches = 0;
    int         cmp_count  = 0;
    logic [7:0] exp_q [$];
    logic       rd_pend    = 1'b0;

    always #4 mclk_i = ~mclk_i;

    acb_config_bank dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .clock_zero_range_bit_i(clock_zero_range_bit_i), .clock_one_range_bit_i(clock_one_range_bit_i),
        .block_out_r0_i(block_out_r0_i), .block_out_r1_i(block_out_r1_i),
        .analog_clock_zero_o(clk0), .analog_clock_one_o(clk1), .sample_hold_disable_o(sample_hold_disable),
        .column_one_input_select_o(col1_sel), .column_two_input_select_o(col2_sel),
        .column_one_odd_group_o(odd_grp), .column_zero_buffer_enable_o(en0), .column_one_buffer_enable_o(en1),
        .column_two_buffer_enable_o(en2), .column_three_buffer_enable_o(en3), .buffer_bypass_o(bypass),
        .buffer_power_level_o(power));

    // ******************************************************************
    // tasks
    // ******************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one bus cycle; idle is both strobes low
    task automatic bus(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i    <= wr;
        reg_rd_i    <= rd;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
    endtask

    task automatic read_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    // ******************************************************************
    // block outputs and range bits change every cycle
    // ******************************************************************
    always @(posedge mclk_i) begin
        block_out_r0_i         <= 8'($random(seed));
        block_out_r1_i         <= 8'($random(seed));
        clock_zero_range_bit_i <= 1'($random(seed));
        clock_one_range_bit_i  <= 1'($random(seed));
    end

    // read answers come one cycle after the strobe
    always @(posedge mclk_i) begin
        if (rd_pend) begin
            check(reg_rdata_o, (exp_q.size() == 0) ? 8'hxx : exp_q.pop_front());
        end
        rd_pend <= reg_rd_i;
    end

    initial begin
        repeat (5000) @(posedge mclk_i);
        mismatches++;
        $display("unexpected at %0t: run did not finish", $time);
        give_verdict();
    end

    // ******************************************************************
    // main sequence
    // ******************************************************************
    initial begin
        logic [7:0] d;
        logic [7:0] buf_val;
        logic [7:0] clk_val;
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        read_exp(acb_pkg::ACB_OFS_CLK_SRC, acb_pkg::ACB_RST_CLK_SRC);
        read_exp(acb_pkg::ACB_OFS_BUF_CTRL, acb_pkg::ACB_RST_BUF_CTRL);
        read_exp(8'h63, 8'h00);
        // walking one, then random, write then read back
        for (int i = 0; i < 40; i++) begin
            d = (i < 8) ? (8'h01 << i) : 8'($random(seed));
            d[5:2] = d[1] ? 4'h0 : d[5:2];
            bus(1'b1, 1'b0, acb_pkg::ACB_OFS_BUF_CTRL, d);
            read_exp(acb_pkg::ACB_OFS_BUF_CTRL, d);
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            #1;
            check(pins, d);
            buf_val = d;
        end
        // every code on both clocks, bit 7 kept zero
        for (int c = 0; c < 8; c++) begin
            d = {1'b0, 1'(c), 3'(c), 3'(7 - c)};
            bus(1'b1, 1'b0, acb_pkg::ACB_OFS_CLK_SRC, d);
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            #1;
            check({6'h00, odd_grp, sample_hold_disable}, {7'h00, d[6]});
            read_exp(acb_pkg::ACB_OFS_CLK_SRC, d);
            repeat (4) bus(1'b0, 1'b0, 8'h00, 8'h00);
            clk_val = d;
        end
        // unmapped write leaves both registers alone
        bus(1'b1, 1'b0, 8'h63, 8'hff);
        read_exp(acb_pkg::ACB_OFS_BUF_CTRL, buf_val);
        read_exp(acb_pkg::ACB_OFS_CLK_SRC, clk_val);
        // reserved bit written as one is not stored
        bus(1'b1, 1'b0, acb_pkg::ACB_OFS_CLK_SRC, 8'h80);
        read_exp(acb_pkg::ACB_OFS_CLK_SRC, 8'h00);
        // second reset in mid-run
        bus(1'b1, 1'b0, acb_pkg::ACB_OFS_BUF_CTRL, 8'hfd);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        check(pins, 8'h00);
        @(posedge mclk_i);
        reset_n_i <= 1'b1;
        read_exp(acb_pkg::ACB_OFS_BUF_CTRL, 8'h00);
        read_exp(acb_pkg::ACB_OFS_CLK_SRC, 8'h00);
        repeat (3) bus(1'b0, 1'b0, 8'h00, 8'h00);
        check(8'(exp_q.size()), 8'h00);
        give_verdict();
    end
endmodule
